// File: pkg/gio_pkg.sv
// constants and types shared by the general-purpose i/o port block
package gio_pkg;

	// port geometry
	localparam int GIO_PORT_W       = 8;
	localparam int GIO_BIT_IDX_W    = 3;
	localparam int GIO_NIBBLE_W     = 4;
	localparam int GIO_PORTS_SMALL  = 3;
	localparam int GIO_PORTS_LARGE  = 5;

	// register index: port p data at 2p, direction at 2p+1
	localparam int GIO_ADDR_W       = 4;
	localparam int GIO_DIR_SEL_BIT  = 0;

	// reset values of data and direction registers
	localparam logic [GIO_PORT_W-1:0] GIO_DATA_RST = 8'hFF;
	localparam logic [GIO_PORT_W-1:0] GIO_DIR_RST  = 8'hFF;
	localparam logic [GIO_PORT_W-1:0] GIO_ZERO     = 8'h00;

	// direction bit encodings
	localparam logic GIO_DIR_IN  = 1'b1;
	localparam logic GIO_DIR_OUT = 1'b0;

	// first port, open-drain capable ports, shared pins
	localparam int GIO_FIRST_PORT   = 0;
	localparam int GIO_OD_PORT_LO   = 1;
	localparam int GIO_OD_PORT_HI   = 2;
	localparam int GIO_TMR_PORT     = 0;
	localparam int GIO_TMR_BIT      = 2;
	localparam int GIO_IRQ_PORT     = 2;
	localparam int GIO_IRQ_BIT      = 2;

	// timer mode field {timer_mode_bit1, timer_mode_bit0}
	localparam logic [1:0] GIO_TM_UNUSED   = 2'h0;
	localparam logic [1:0] GIO_TM_EVENT    = 2'h1;
	localparam logic [1:0] GIO_TM_INTERNAL = 2'h2;
	localparam logic [1:0] GIO_TM_PULSE    = 2'h3;

	// power state of the wake-up monitor
	typedef enum logic [1:0] {
		gio_st_run,
		gio_st_sleep,
		gio_st_waking
	} gio_pwr_t;

endpackage

// File: pkg/gio_wake_if.sv
// carrier between the port block and its wake-up monitor
`timescale 1ns/1ps
interface gio_wake_if #(
	parameter int N = 24
);
	logic         halt;
	logic         resumed;
	logic [N-1:0] pin;
	logic [N-1:0] mask;
	logic         wake_req;
	logic         asleep;

	modport ctl (
		output halt,
		output resumed,
		output pin,
		output mask,
		input  wake_req,
		input  asleep
	);

	modport wk (
		input  halt,
		input  resumed,
		input  pin,
		input  mask,
		output wake_req,
		output asleep
	);
endinterface

// File: logic/gio_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module gio_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// File: logic/gio_wake.sv
// power-down tracker and any-edge wake-up detector
`timescale 1ns/1ps
module gio_wake (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// link to the port block
	gio_wake_if.wk    wif
);
	import gio_pkg::*;

	gio_pwr_t             state;
	gio_pwr_t             next_state;
	logic [$bits(wif.pin)-1:0] prev;
	logic                 edge_seen;

	assign edge_seen = |((wif.pin ^ prev) & wif.mask);

	always_comb begin
		next_state = state;
		unique case (state)
			gio_st_run: begin
				if (wif.halt) begin
					next_state = gio_st_sleep;
				end
			end
			gio_st_sleep: begin
				// another wake source may restart the core first
				if (wif.resumed) begin
					next_state = gio_st_run;
				end else if (edge_seen) begin
					next_state = gio_st_waking;
				end
			end
			gio_st_waking: begin
				if (wif.resumed) begin
					next_state = gio_st_run;
				end
			end
			default: begin
				next_state = gio_st_run;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state        <= gio_st_run;
			prev         <= '0;
			wif.wake_req <= 1'b0;
			wif.asleep   <= 1'b0;
		end else begin
			state        <= next_state;
			prev         <= wif.pin;
			wif.wake_req <= (next_state == gio_st_waking);
			wif.asleep   <= (next_state != gio_st_run);
		end
	end
endmodule

// File: logic/gio_ports.sv
// bidirectional i/o ports with direction, pull-high, open-drain and wake-up
`timescale 1ns/1ps

module gio_ports
	import gio_pkg::*;
#(
	parameter int NUM_PORTS     = 3,
	parameter int IN_ONLY_PORT  = 2,
	parameter int IN_ONLY_BIT   = 7,
	parameter int N             = NUM_PORTS * gio_pkg::GIO_PORT_W
) (
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            srst,
	// data memory access from the core
	input  wire logic [gio_pkg::GIO_ADDR_W-1:0]  reg_addr,
	input  wire logic                            reg_wr,
	input  wire logic [gio_pkg::GIO_PORT_W-1:0]  reg_wdata,
	input  wire logic                            reg_rd,
	output logic      [gio_pkg::GIO_PORT_W-1:0]  reg_rdata,
	input  wire logic                            bit_set,
	input  wire logic                            bit_clr,
	input  wire logic [gio_pkg::GIO_BIT_IDX_W-1:0] bit_sel,
	// pins
	input  wire logic [N-1:0]                    pin_in,
	output logic      [N-1:0]                    pin_out,
	output logic      [N-1:0]                    pin_oe,
	output logic      [N-1:0]                    pin_pull_en,
	// configuration options
	input  wire logic [gio_pkg::GIO_PORT_W-1:0]  opt_first_pull,
	input  wire logic [NUM_PORTS-1:0]            opt_grp_pull_en,
	input  wire logic [NUM_PORTS-1:0]            opt_grp_pull_upper,
	input  wire logic [NUM_PORTS-1:0]            opt_open_drain,
	input  wire logic [N-1:0]                    opt_wake_en,
	// shared pin functions
	input  wire logic [1:0]                      timer_mode,
	output logic                                 timer_event_input,
	output logic                                 irq_shared_pin,
	// power-down
	input  wire logic                            halt,
	input  wire logic                            core_resumed,
	output logic                                 wake_req,
	output logic                                 power_down
);
	import gio_pkg::*;

	localparam int PW = GIO_PORT_W;

	generate
		if (NUM_PORTS != GIO_PORTS_SMALL && NUM_PORTS != GIO_PORTS_LARGE)
		begin : bad_ports
			$error("gio_ports: NUM_PORTS must be 3 or 5");
		end
		if (IN_ONLY_PORT >= NUM_PORTS || IN_ONLY_BIT >= PW ||
			NUM_PORTS <= GIO_IRQ_PORT) begin : bad_pos
			$error("gio_ports: input-only or shared pin out of range");
		end
		if (N != NUM_PORTS * PW) begin : bad_width
			$error("gio_ports: N must equal NUM_PORTS times port width");
		end
	endgenerate

	// register state
	logic [NUM_PORTS-1:0][PW-1:0] port_data;
	logic [NUM_PORTS-1:0][PW-1:0] port_dir;
	logic [NUM_PORTS-1:0][PW-1:0] next_data;
	logic [NUM_PORTS-1:0][PW-1:0] next_dir;
	logic [PW-1:0]                next_rdata;

	// pin driver state
	logic [N-1:0]                 next_out;
	logic [N-1:0]                 next_oe;
	logic [N-1:0]                 next_pull;
	logic                         next_tev;
	logic                         next_irq;

	// synchronised pins and the value software sees
	logic [N-1:0]                 pin_sync;
	logic [NUM_PORTS-1:0][PW-1:0] port_view;

	// address decode
	logic [GIO_ADDR_W-2:0]        sel_port;
	logic                         sel_dir;
	logic                         mapped;
	logic [PW-1:0]                rmw_val;

	gio_wake_if #(.N(N)) wif ();

	gio_sync #(
		.W(N)
	) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    (pin_in),
		.q    (pin_sync)
	);

	gio_wake u_wake (
		.clk  (clk),
		.srst (srst),
		.wif  (wif.wk)
	);

	assign sel_port = reg_addr[GIO_ADDR_W-1:1];
	assign sel_dir  = reg_addr[GIO_DIR_SEL_BIT];
	assign mapped   = (int'(sel_port) < NUM_PORTS);

	// per pin: view, drivers, pull-high, wake mask
	genvar gp, gb;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			for (gb = 0; gb < PW; gb++) begin : g_bit
				localparam int I = gp * PW + gb;
				localparam bit IN_ONLY =
					(gp == IN_ONLY_PORT) && (gb == IN_ONLY_BIT);
				localparam bit OD_OK =
					(gp >= GIO_OD_PORT_LO) && (gp <= GIO_OD_PORT_HI);
				localparam bit UPPER = (gb >= GIO_NIBBLE_W);
				logic is_in;
				logic od;

				assign is_in = (port_dir[gp][gb] == GIO_DIR_IN);
				assign od    = OD_OK && opt_open_drain[gp];

				// inputs read the pin, outputs read the latch
				assign port_view[gp][gb] = is_in ? pin_sync[I]
					: port_data[gp][gb];

				// open-drain only sinks; push-pull drives the latch
				assign next_out[I] = od ? 1'b0 : port_data[gp][gb];
				assign next_oe[I]  = !is_in && !IN_ONLY &&
					!(od && port_data[gp][gb]);

				if (gp == GIO_FIRST_PORT) begin : g_pa
					assign next_pull[I] = is_in &&
						opt_first_pull[gb];
				end else begin : g_pg
					assign next_pull[I] = is_in && opt_grp_pull_en[gp] &&
						(opt_grp_pull_upper[gp] == UPPER);
				end

				assign wif.mask[I] = is_in && opt_wake_en[I];
			end
		end
	endgenerate

	// shared timer pin only in event-counter and pulse-width modes
	always_comb begin
		next_tev = 1'b0;
		next_irq = pin_sync[GIO_IRQ_PORT * PW + GIO_IRQ_BIT];
		unique case (timer_mode)
			GIO_TM_EVENT, GIO_TM_PULSE: begin
				next_tev = pin_sync[GIO_TMR_PORT * PW + GIO_TMR_BIT];
			end
			GIO_TM_INTERNAL, GIO_TM_UNUSED: begin
				next_tev = 1'b0;
			end
		endcase
	end

	// register writes, bit operations, reads
	always_comb begin
		next_data  = port_data;
		next_dir   = port_dir;
		next_rdata = reg_rdata;
		rmw_val    = GIO_ZERO;
		if (mapped) begin
			rmw_val = sel_dir ? port_dir[sel_port] : port_view[sel_port];
			if (reg_wr) begin
				if (sel_dir) begin
					next_dir[sel_port] = reg_wdata;
				end else begin
					next_data[sel_port] = reg_wdata;
				end
			end else if (bit_set || bit_clr) begin
				// whole port read back, one bit changed, byte rewritten
				rmw_val[bit_sel] = bit_set;
				if (sel_dir) begin
					next_dir[sel_port] = rmw_val;
				end else begin
					next_data[sel_port] = rmw_val;
				end
			end
		end
		if (reg_rd) begin
			if (!mapped) begin
				next_rdata = GIO_ZERO;
			end else if (sel_dir) begin
				next_rdata = port_dir[sel_port];
			end else begin
				next_rdata = port_view[sel_port];
			end
		end
		// the input-only line never becomes an output
		next_dir[IN_ONLY_PORT][IN_ONLY_BIT] = GIO_DIR_IN;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			port_data         <= {NUM_PORTS{GIO_DATA_RST}};
			port_dir          <= {NUM_PORTS{GIO_DIR_RST}};
			reg_rdata         <= GIO_ZERO;
			pin_out           <= '0;
			pin_oe            <= '0;
			pin_pull_en       <= '0;
			timer_event_input <= 1'b0;
			irq_shared_pin    <= 1'b0;
		end else begin
			port_data         <= next_data;
			port_dir          <= next_dir;
			reg_rdata         <= next_rdata;
			pin_out           <= next_out;
			pin_oe            <= next_oe;
			pin_pull_en       <= next_pull;
			timer_event_input <= next_tev;
			irq_shared_pin    <= next_irq;
		end
	end

	// power-down and wake-up
	assign wif.halt    = halt;
	assign wif.resumed = core_resumed;
	assign wif.pin     = pin_sync;
	assign wake_req    = wif.wake_req;
	assign power_down  = wif.asleep;
endmodule

// File: bench/gio_pin_model.sv
// pin-side circuitry: switches that may drive pins, else pull or float
`timescale 1ns/1ps
module gio_pin_model #(
	parameter int N = 24
) (
	// clock
	input  wire logic         clk,
	// block side
	input  wire logic [N-1:0] pin_out,
	input  wire logic [N-1:0] pin_oe,
	input  wire logic [N-1:0] pin_pull_en,
	// switch side
	input  wire logic [N-1:0] ext_en,
	input  wire logic [N-1:0] ext_val,
	output logic      [N-1:0] pin_in
);
	logic flip = 1'b0;

	always @(posedge clk) flip <= ~flip;

	// a floating line wanders, so a stale level is never read back
	always_comb begin
		for (int i = 0; i < N; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] :
				ext_en[i] ? ext_val[i] : pin_pull_en[i] | flip;
		end
	end
endmodule

// File: bench/gio_ports_chk.sv
// port-level assertions for the i/o port block
`timescale 1ns/1ps
module gio_ports_chk
	import gio_pkg::*;
#(
	parameter int NUM_PORTS = 3,
	parameter int N         = 24
) (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   srst,
	// register access
	input wire logic [GIO_ADDR_W-1:0]  reg_addr,
	input wire logic                   reg_wr,
	input wire logic [GIO_PORT_W-1:0]  reg_wdata,
	input wire logic                   reg_rd,
	input wire logic [GIO_PORT_W-1:0]  reg_rdata,
	input wire logic                   bit_set,
	input wire logic                   bit_clr,
	// pins and options
	input wire logic [N-1:0]           pin_out,
	input wire logic [N-1:0]           pin_oe,
	input wire logic [N-1:0]           pin_pull_en,
	input wire logic [NUM_PORTS-1:0]   opt_open_drain,
	// shared functions and power
	input wire logic [1:0]             timer_mode,
	input wire logic                   timer_event_input,
	input wire logic                   halt,
	input wire logic                   core_resumed,
	input wire logic                   wake_req,
	input wire logic                   power_down
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_rst_idle: assert property (disable iff (1'b0) srst |=>
		pin_oe == '0 && !power_down && !wake_req) else $error("not idle");
	a_pull_input: assert property ((pin_pull_en & pin_oe) == '0)
		else $error("pull on a driven pin");
	a_halt_sleep: assert property (halt && !power_down && !wake_req
		&& !core_resumed |=> power_down) else $error("halt ignored");
	a_sleep_hold: assert property (power_down && !core_resumed |=>
		power_down) else $error("left power-down early");
	a_wake_asleep: assert property ($rose(wake_req) |-> power_down)
		else $error("wake while running");
	a_wake_hold: assert property (wake_req && !core_resumed |=>
		wake_req) else $error("wake request dropped");
	a_wake_clear: assert property (core_resumed && power_down |=>
		!power_down && !wake_req) else $error("resume not seen");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	a_timer_gate: assert property (!timer_mode[0] |=>
		!timer_event_input) else $error("timer input leaks");
	a_input_only: assert property (!pin_oe[23])
		else $error("input-only line driven");
	a_dir_drive: assert property (reg_wr && reg_addr == 4'h1 ##1
		!(reg_wr || bit_set || bit_clr) |=>
		pin_oe[7:0] == ~$past(reg_wdata, 2)) else $error("bad enable");
	a_od_low: assert property (opt_open_drain[1] &&
		$past(opt_open_drain[1]) |-> pin_out[15:8] == 8'h00)
		else $error("open-drain drives high");
endmodule

// File: bench/gio_ports_bench.sv
// self-checking bench for the i/o port block
`timescale 1ns/1ps
bind gio_ports gio_ports_chk #(.NUM_PORTS(NUM_PORTS), .N(N))
	i_gio_ports_chk (
		.clk               (clk),
		.srst              (srst),
		.reg_addr          (reg_addr),
		.reg_wr            (reg_wr),
		.reg_wdata         (reg_wdata),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.bit_set           (bit_set),
		.bit_clr           (bit_clr),
		.pin_out           (pin_out),
		.pin_oe            (pin_oe),
		.pin_pull_en       (pin_pull_en),
		.opt_open_drain    (opt_open_drain),
		.timer_mode        (timer_mode),
		.timer_event_input (timer_event_input),
		.halt              (halt),
		.core_resumed      (core_resumed),
		.wake_req          (wake_req),
		.power_down        (power_down)
	);

module gio_ports_bench;
	import gio_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, opt_first_pull = 8'h3C;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, bit_set = 1'b0;
	logic        bit_clr = 1'b0, halt = 1'b0, core_resumed = 1'b0;
	logic [2:0]  bit_sel = 3'h0, opt_grp_pull_en = 3'h6;
	logic [2:0]  opt_grp_pull_upper = 3'h2, opt_open_drain = 3'h2;
	logic [23:0] pin_in, pin_out, pin_oe, pin_pull_en;
	logic [23:0] opt_wake_en = 24'h000100, ext_en = 24'h0, ext_val = 24'h0;
	logic [1:0]  timer_mode = GIO_TM_INTERNAL;
	logic        timer_event_input, irq_shared_pin, wake_req, power_down;
	int          miscompares = 0, num_checks = 0, cyc = 0;

	gio_ports i_gio_ports (.*);
	gio_pin_model i_gio_pin_model (.*);

	always #5 clk = ~clk;

	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		chk(24'(reg_rdata), 24'(e));
	endtask

	task automatic bop(input logic [3:0] a, input logic [2:0] b, input logic s);
		@(posedge clk);
		reg_addr <= a;
		bit_sel <= b;
		bit_set <= s;
		bit_clr <= !s;
		@(posedge clk);
		bit_set <= 1'b0;
		bit_clr <= 1'b0;
	endtask

	task automatic t_reset();
		for (int p = 0; p < 3; p++) rd(4'(2 * p + 1), 8'hFF);
		rd(4'h6, 8'h00);
		chk(pin_oe, 24'h0);
		chk(pin_pull_en, 24'h0FF03C);
		wr(4'h1, 8'h00);
		tick(2);
		chk(pin_out[7:0], 8'hFF);
		chk(pin_pull_en[7:0], 8'h00);
	endtask

	task automatic t_latch_input();
		wr(4'h0, 8'h5A);
		ext_en[15:8] <= 8'hFF;
		ext_val[15:8] <= 8'hA5;
		tick(6);
		chk(pin_out[7:0], 8'h5A);
		rd(4'h0, 8'h5A);
		rd(4'h2, 8'hA5);
		ext_val[15:8] <= 8'h3C;
		tick(3);
		rd(4'h2, 8'h3C);
	endtask

	task automatic t_open_drain();
		wr(4'h3, 8'h00);
		wr(4'h2, 8'h0F);
		tick(2);
		chk(pin_oe[15:8], 8'hF0);
		chk(pin_out[15:8], 8'h00);
		rd(4'h2, 8'h0F);
		// push-pull on port 1; the option is ignored on port 0
		opt_open_drain <= 3'h1;
		tick(2);
		chk(pin_oe[15:8], 8'hFF);
		chk(pin_out[15:8], 8'h0F);
		chk(pin_oe[7:0], 8'hFF);
		chk(pin_out[7:0], 8'h5A);
		opt_open_drain <= 3'h2;
		tick(1);
	endtask

	task automatic t_bits();
		ext_en[7:4] <= 4'hF;
		ext_val[7:4] <= 4'hA;
		wr(4'h1, 8'hF0);
		wr(4'h0, 8'h00);
		tick(3);
		bop(4'h0, 3'h0, 1'b1);
		wr(4'h1, 8'h00);
		tick(2);
		chk(pin_out[7:0], 8'hA1);
		bop(4'h5, 3'h1, 1'b0);
		rd(4'h5, 8'hFD);
		chk(pin_oe[23:16], 8'h02);
		wr(4'h5, 8'h00);
		rd(4'h5, 8'h80);
		chk(pin_oe[23], 1'b0);
	endtask

	task automatic t_shared();
		wr(4'h0, 8'h04);
		timer_mode <= GIO_TM_EVENT;
		tick(5);
		chk(timer_event_input, 1'b1);
		chk(irq_shared_pin, 1'b1);
		timer_mode <= GIO_TM_PULSE;
		tick(2);
		chk(timer_event_input, 1'b1);
		timer_mode <= GIO_TM_UNUSED;
		tick(2);
		chk(timer_event_input, 1'b0);
		wr(4'h4, 8'hFB);
		tick(5);
		chk(irq_shared_pin, 1'b0);
		timer_mode <= GIO_TM_INTERNAL;
		tick(3);
		chk(timer_event_input, 1'b0);
	endtask

	task automatic t_wake();
		wr(4'h3, 8'hFF);
		tick(3);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		tick(4);
		chk(power_down, 1'b1);
		chk(wake_req, 1'b0);
		ext_val[8] <= ~ext_val[8];
		for (int i = 0; i < 8 && wake_req !== 1'b1; i++) @(posedge clk);
		tick(3);
		chk(wake_req, 1'b1);
		core_resumed <= 1'b1;
		@(posedge clk);
		core_resumed <= 1'b0;
		tick(1);
		chk({power_down, wake_req}, 24'h0);
	endtask

	// reset in mid-run must restore the registers changed above
	task automatic t_rerun();
		srst <= 1'b1;
		tick(3);
		srst <= 1'b0;
		@(posedge clk);
		chk(pin_oe, 24'h0);
		chk({power_down, wake_req}, 24'h0);
		rd(4'h5, 8'hFF);
		wr(4'h1, 8'h00);
		tick(2);
		chk(pin_out[7:0], 8'hFF);
	endtask

	task automatic close_out();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			close_out();
		end
	end

	initial begin
		tick(3);
		srst <= 1'b0;
		t_reset();
		t_latch_input();
		t_open_drain();
		t_bits();
		t_shared();
		t_wake();
		t_rerun();
		close_out();
	end
endmodule
